// file: core/ucbr_defs.svh
// register indices, field positions and timing counts for the uart control block
// assumes an apb slave with 32-bit data, one register per aligned word (byte address = index * 4)
`ifndef UCBR_DEFS_SVH
`define UCBR_DEFS_SVH

// register indices
`define UCBR_IDX_PWR 8'h87
`define UCBR_IDX_CTRL 8'h98
`define UCBR_IDX_DATA 8'h99
`define UCBR_IDX_BAUD 8'h9E

// control/status fields
`define UCBR_F_MODE 7:6
`define UCBR_B_FILT 5
`define UCBR_B_FE 7
`define UCBR_B_OVR 6
`define UCBR_B_COL 5
`define UCBR_B_REN 4
`define UCBR_B_TB8 3
`define UCBR_B_RB8 2
`define UCBR_B_TI 1
`define UCBR_B_RI 0

// power control fields
`define UCBR_B_SMOD 7
`define UCBR_B_SEL 6

// bit times in system clocks
`define UCBR_BT_SYNC_SLOW 16'h000C
`define UCBR_BT_SYNC_FAST 16'h0004
`define UCBR_BT_FIX_SLOW 16'h0040
`define UCBR_BT_FIX_FAST 16'h0020
`define UCBR_OVS 16'h0010

`endif

// file: core/ucbr_pkg.sv
// types of the uart control block: frame modes, engine phases, state records
// assumes ucbr_defs.svh supplies the numeric constants
package ucbr_pkg;
  typedef enum logic [1:0] {
    UCBR_M_SYNC = 2'h0,
    UCBR_M_ASYNC8 = 2'h1,
    UCBR_M_ASYNC9F = 2'h2,
    UCBR_M_ASYNC9V = 2'h3
  } ucbr_mode_t;

  typedef enum logic [2:0] {
    UCBR_IDLE = 3'h0,
    UCBR_START = 3'h1,
    UCBR_DATA = 3'h2,
    UCBR_NINTH = 3'h3,
    UCBR_STOP = 3'h4
  } ucbr_phase_t;

  typedef struct packed {
    ucbr_mode_t mode;
    logic filt, ren, tb8, rb8, ti, ri;
    logic fe, ovr, col, smod, sel;
    logic [7:0] baud;
    logic [7:0] rbuf;
    logic unread;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic txd, rxd_out, rxd_oe_n;
    ucbr_phase_t tx_st;
    logic [8:0] tx_sh;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    ucbr_phase_t rx_st;
    logic [7:0] rx_sh;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_m0, rx_n9;
  } ucbr_state_t;

  typedef struct packed {
    logic ff1, ff2, ff3, q;
  } ucbr_sync_t;
endpackage : ucbr_pkg

// file: core/ucbr_sync.sv
// three-stage synchroniser with agreement filter for the serial receive pin
// assumes din is asynchronous to pclk; dout idles at RST_VAL after reset
module ucbr_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  ucbr_pkg::ucbr_sync_t s, n;

  // ff1 feeds only ff2; a change is taken once ff2 and ff3 agree
  always_comb begin
    n = s;
    n.ff1 = din;
    n.ff2 = s.ff1;
    n.ff3 = s.ff2;
    if (s.ff2 == s.ff3) n.q = s.ff3;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s <= n;
    end
  end

  assign dout = s.q;
endmodule : ucbr_sync

// file: core/ucbr_top.sv
// uart control/status and data buffer registers with tx/rx frame engines, apb slave
// assumes pclk 200 MHz, presetn async active low, rxd_in asynchronous to pclk
`include "ucbr_defs.svh"

module ucbr_top #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd_out
);
  ucbr_pkg::ucbr_state_t s, n;
  logic rxs;
  logic wr, rd;
  logic [7:0] w;
  logic [15:0] bt, half;
  logic tx_ev, rx_ev, tx_busy;
  logic rx_latch, stop_bad, nine_eff;

  // register index to byte address match
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : at

  // bit time in clocks for the current frame mode
  function automatic logic [15:0] bit_time(input ucbr_pkg::ucbr_mode_t m, input logic f, input logic sm,
                                           input logic [7:0] b);
    case (m)
      ucbr_pkg::UCBR_M_SYNC: bit_time = f ? `UCBR_BT_SYNC_FAST : `UCBR_BT_SYNC_SLOW;
      ucbr_pkg::UCBR_M_ASYNC9F: bit_time = sm ? `UCBR_BT_FIX_FAST : `UCBR_BT_FIX_SLOW;
      default: bit_time = {4'h0, b, 4'h0} + `UCBR_OVS; // variable rate: (baud+1)*16
    endcase
  endfunction : bit_time

  // rx pin resynchronised; sync-mode sampling lags by four clocks, so fast rate needs slow partners
  ucbr_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(rxd_in),
    .dout(rxs)
  );

  // whole next-state function
  always_comb begin
    n = s;
    w = pwdata[7:0];
    wr = psel & penable & s.pready & pwrite;
    rd = psel & penable & s.pready & ~pwrite;
    bt = bit_time(s.mode, s.filt, s.smod, s.baud);
    half = bt >> 1;
    tx_ev = s.tx_cnt == 16'h0000;
    rx_ev = s.rx_cnt == 16'h0000;
    tx_busy = (s.tx_st != ucbr_pkg::UCBR_IDLE) | (s.rx_m0 & (s.rx_st != ucbr_pkg::UCBR_IDLE));
    rx_latch = 1'b0;
    stop_bad = 1'b0;
    nine_eff = (s.mode == ucbr_pkg::UCBR_M_ASYNC8) ? rxs : s.rx_n9;

    // apb: answer prepared in setup, so the access phase never waits
    n.pready = psel & ~penable;
    if (psel & ~penable) begin
      n.pslverr = ~(at(paddr, `UCBR_IDX_CTRL) | at(paddr, `UCBR_IDX_DATA) | at(paddr, `UCBR_IDX_PWR) |
                    at(paddr, `UCBR_IDX_BAUD));
      n.prdata = 32'h0000_0000;
      if (at(paddr, `UCBR_IDX_CTRL)) begin
        n.prdata[7:0] = {s.sel ? {s.fe, s.ovr, s.col} : {s.mode, s.filt},
                         s.ren, s.tb8, s.rb8, s.ti, s.ri};
      end
      if (at(paddr, `UCBR_IDX_DATA)) n.prdata[7:0] = s.rbuf;
      if (at(paddr, `UCBR_IDX_PWR)) n.prdata[7:0] = {s.smod, s.sel, 6'h00};
      if (at(paddr, `UCBR_IDX_BAUD)) n.prdata[7:0] = s.baud;
    end

    // reading the latch marks it consumed
    if (rd & at(paddr, `UCBR_IDX_DATA)) n.unread = 1'b0;

    // control writes; flags only clear by writing zero, hardware sets below win
    if (wr & at(paddr, `UCBR_IDX_CTRL)) begin
      if (s.sel) begin
        n.fe = s.fe & w[`UCBR_B_FE];
        n.ovr = s.ovr & w[`UCBR_B_OVR];
        n.col = s.col & w[`UCBR_B_COL];
      end else begin
        n.mode = ucbr_pkg::ucbr_mode_t'(w[`UCBR_F_MODE]);
        n.filt = w[`UCBR_B_FILT];
      end
      n.ren = w[`UCBR_B_REN];
      n.tb8 = w[`UCBR_B_TB8];
      n.rb8 = w[`UCBR_B_RB8];
      n.ti = w[`UCBR_B_TI];
      n.ri = w[`UCBR_B_RI];
    end
    if (wr & at(paddr, `UCBR_IDX_PWR)) begin
      n.smod = w[`UCBR_B_SMOD];
      n.sel = w[`UCBR_B_SEL];
    end
    if (wr & at(paddr, `UCBR_IDX_BAUD)) n.baud = w;

    // data write starts a frame, or is dropped if one is running
    if (wr & at(paddr, `UCBR_IDX_DATA)) begin
      if (tx_busy) begin
        n.col = 1'b1;
      end else begin
        n.tx_sh = {s.tb8, w};
        n.tx_cnt = bt - 16'h0001;
        n.tx_bit = 3'h0;
        n.txd = 1'b0;
        if (s.mode == ucbr_pkg::UCBR_M_SYNC) begin
          n.tx_st = ucbr_pkg::UCBR_DATA;
          n.rxd_oe_n = 1'b0;
          n.rxd_out = w[0];
        end else begin
          n.tx_st = ucbr_pkg::UCBR_START; // start bit low
        end
      end
    end

    // receive engine
    if (!s.ren) begin
      n.rx_st = ucbr_pkg::UCBR_IDLE;
      n.rx_m0 = 1'b0;
      if (s.rx_m0 & (s.rx_st != ucbr_pkg::UCBR_IDLE)) n.txd = 1'b1;
    end else begin
      if (s.rx_st != ucbr_pkg::UCBR_IDLE) begin
        n.rx_cnt = rx_ev ? bt - 16'h0001 : s.rx_cnt - 16'h0001;
      end
      case (s.rx_st)
        ucbr_pkg::UCBR_IDLE: begin
          if (s.mode == ucbr_pkg::UCBR_M_SYNC) begin
            // sync receive needs the line and shift clock to itself
            if (!s.ri & !tx_busy & !(wr & at(paddr, `UCBR_IDX_DATA))) begin
              n.rx_st = ucbr_pkg::UCBR_DATA;
              n.rx_m0 = 1'b1;
              n.rx_cnt = bt - 16'h0001;
              n.rx_bit = 3'h0;
              n.txd = 1'b0;
            end
          end else if (!rxs) begin
            n.rx_st = ucbr_pkg::UCBR_START;
            n.rx_m0 = 1'b0;
            n.rx_cnt = half - 16'h0001;
          end
        end
        ucbr_pkg::UCBR_START: begin
          // mid start bit: a high line was a glitch
          if (rx_ev) n.rx_st = rxs ? ucbr_pkg::UCBR_IDLE : ucbr_pkg::UCBR_DATA;
          n.rx_bit = 3'h0;
        end
        ucbr_pkg::UCBR_DATA: begin
          if (s.rx_m0) begin
            if (s.rx_cnt == half) begin
              n.txd = 1'b1;
              n.rx_sh = {rxs, s.rx_sh[7:1]};
            end
            if (rx_ev) begin
              n.txd = 1'b0;
              n.rx_bit = s.rx_bit + 3'h1;
              if (s.rx_bit == 3'h7) begin
                n.txd = 1'b1;
                n.rx_st = ucbr_pkg::UCBR_IDLE;
                n.rx_m0 = 1'b0;
                rx_latch = 1'b1; // done after 8th bit, ninth flag untouched
              end
            end
          end else if (rx_ev) begin
            n.rx_sh = {rxs, s.rx_sh[7:1]}; // lsb first
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7) begin
              n.rx_st = s.mode[1] ? ucbr_pkg::UCBR_NINTH : ucbr_pkg::UCBR_STOP; // 9-bit modes
            end
          end
        end
        ucbr_pkg::UCBR_NINTH: begin
          if (rx_ev) begin
            n.rx_n9 = rxs;
            n.rx_st = ucbr_pkg::UCBR_STOP;
          end
        end
        ucbr_pkg::UCBR_STOP: begin
          if (rx_ev) begin
            stop_bad = !rxs;
            if (stop_bad) n.fe = 1'b1;
            if (!s.filt | nine_eff) begin
              rx_latch = 1'b1;
              n.rb8 = nine_eff;
            end
            n.rx_st = ucbr_pkg::UCBR_IDLE;
          end
        end
        default: n.rx_st = ucbr_pkg::UCBR_IDLE;
      endcase
    end

    // latching into the receive buffer; an unread byte is lost
    if (rx_latch) begin
      n.rbuf = s.rx_sh;
      n.ri = 1'b1;
      if (s.unread) n.ovr = 1'b1;
      n.unread = 1'b1;
    end

    // transmit engine
    if (s.tx_st != ucbr_pkg::UCBR_IDLE) begin
      n.tx_cnt = tx_ev ? bt - 16'h0001 : s.tx_cnt - 16'h0001;
      case (s.tx_st)
        ucbr_pkg::UCBR_START: begin
          if (tx_ev) begin
            n.txd = s.tx_sh[0];
            n.tx_sh = s.tx_sh >> 1;
            n.tx_st = ucbr_pkg::UCBR_DATA;
          end
        end
        ucbr_pkg::UCBR_DATA: begin
          if (s.mode == ucbr_pkg::UCBR_M_SYNC) begin
            if (s.tx_cnt == half) n.txd = 1'b1; // shift clock high for second half
            if (tx_ev) begin
              n.txd = 1'b0;
              n.tx_sh = s.tx_sh >> 1;
              n.rxd_out = s.tx_sh[1];
              n.tx_bit = s.tx_bit + 3'h1;
              if (s.tx_bit == 3'h7) begin
                n.tx_st = ucbr_pkg::UCBR_IDLE;
                n.ti = 1'b1; // end of 8th bit
                n.txd = 1'b1;
                n.rxd_out = 1'b1;
                n.rxd_oe_n = 1'b1;
              end
            end
          end else if (tx_ev) begin
            n.txd = s.tx_sh[0];
            n.tx_sh = s.tx_sh >> 1;
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == 3'h7) begin
              if (s.mode[1]) begin
                n.tx_st = ucbr_pkg::UCBR_NINTH; // ninth bit is the saved tb8
              end else begin
                n.txd = 1'b1;
                n.ti = 1'b1;
                n.tx_st = ucbr_pkg::UCBR_STOP;
              end
            end
          end
        end
        ucbr_pkg::UCBR_NINTH: begin
          if (tx_ev) begin
            n.txd = 1'b1; // stop bit high
            n.ti = 1'b1;
            n.tx_st = ucbr_pkg::UCBR_STOP;
          end
        end
        ucbr_pkg::UCBR_STOP: begin
          if (tx_ev) n.tx_st = ucbr_pkg::UCBR_IDLE;
        end
        default: n.tx_st = ucbr_pkg::UCBR_IDLE;
      endcase
    end
  end

  // state register; lines idle high, everything else zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.txd <= 1'b1;
      s.rxd_out <= 1'b1;
      s.rxd_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txd_out = s.txd;
  assign rxd_out = s.rxd_out;
  assign rxd_oe_n = s.rxd_oe_n;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_TX_COLLIDE: assert property (wr && at(paddr, `UCBR_IDX_DATA) && tx_busy |=> s.col)
    else $error("collision flag not set on busy write");
  AST_TX_START: assert property (wr && at(paddr, `UCBR_IDX_DATA) && !tx_busy |=>
    s.tx_st == (s.mode == ucbr_pkg::UCBR_M_SYNC ? ucbr_pkg::UCBR_DATA : ucbr_pkg::UCBR_START))
    else $error("data write did not start a frame");
  AST_SYNC_RATE: assert property (wr && at(paddr, `UCBR_IDX_DATA) && !tx_busy &&
    s.mode == ucbr_pkg::UCBR_M_SYNC |=> s.tx_cnt == (s.filt ? `UCBR_BT_SYNC_FAST : `UCBR_BT_SYNC_SLOW) - 16'h0001)
    else $error("sync bit time wrong");
  AST_TI_AT_STOP: assert property (s.tx_st != ucbr_pkg::UCBR_STOP ##1
    s.tx_st == ucbr_pkg::UCBR_STOP |-> s.ti)
    else $error("tx done not set at stop start");
  AST_REN_OFF: assert property (!s.ren |=> s.rx_st == ucbr_pkg::UCBR_IDLE)
    else $error("receiver active while disabled");
  AST_FRAME_ERR: assert property (stop_bad |=> s.fe)
    else $error("low stop bit not flagged");
  AST_OVERRUN: assert property (rx_latch && s.unread |=> s.ovr && s.unread)
    else $error("overrun not flagged");
  AST_FILTER: assert property (s.rx_st == ucbr_pkg::UCBR_STOP && rx_ev && s.ren && s.filt &&
    !nine_eff && !s.ri && !(wr && at(paddr, `UCBR_IDX_CTRL)) |=> !s.ri && s.rbuf == $past(s.rbuf))
    else $error("filtered byte raised rx done");
  AST_BANK_READ: assert property (psel && !penable && at(paddr, `UCBR_IDX_CTRL) && s.sel |=>
    s.prdata[7] == $past(s.fe) && s.prdata[6] == $past(s.ovr) && s.prdata[5] == $past(s.col))
    else $error("flag bank not shown");
  AST_RBUF_READ: assert property (psel && !penable && at(paddr, `UCBR_IDX_DATA) |=>
    s.prdata[7:0] == $past(s.rbuf) && s.pready)
    else $error("data read not from receive latch");
  AST_SYNC_RB8: assert property (rx_latch && s.rx_m0 && !(wr && at(paddr, `UCBR_IDX_CTRL)) |=>
    s.rb8 == $past(s.rb8) && s.ri)
    else $error("sync receive touched ninth bit");

  COV_ASYNC_TX: cover property (s.tx_st == ucbr_pkg::UCBR_NINTH ##1 s.tx_st == ucbr_pkg::UCBR_STOP);
  COV_RX_LATCH: cover property (rx_latch && s.filt);
  COV_COLLIDE: cover property (wr && at(paddr, `UCBR_IDX_DATA) && tx_busy);
  COV_SYNC_RX: cover property (rx_latch && s.rx_m0);
endmodule : ucbr_top

// file: testbench/test_uart_control_and_buffer_regs.sv
// self-checking bench: apb register traffic plus a remote serial station
// assumes ucbr_top with default address width; reads and frames checked from queues
`include "ucbr_defs.svh"

module test_uart_control_and_buffer_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_PWR = 12'(`UCBR_IDX_PWR) << 2;
  localparam logic [11:0] A_CTRL = 12'(`UCBR_IDX_CTRL) << 2;
  localparam logic [11:0] A_DATA = 12'(`UCBR_IDX_DATA) << 2;
  localparam logic [11:0] A_BAUD = 12'(`UCBR_IDX_BAUD) << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_out, rxd_oe_n, txd_out, got_frame, remote_line;
  wire logic rxd_line;
  logic [10:0] frame;
  logic [64:0] rd_q[$];
  logic [64:0] e;
  logic [31:0] tx_q[$];
  logic [7:0] d, r;
  int num_errors = 0;
  int samples_checked = 0;
  int frames_sent = 0;
  int frames_seen = 0;
  int seed = 32'h48DD;

  always #2.5 pclk = ~pclk;
  // device drives the shared pin only in sync transmit
  assign rxd_line = rxd_oe_n ? remote_line : rxd_out;

  ucbr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));
  ucbr_remote #(.BIT_T(16)) remote_u (.pclk(pclk), .line_in(txd_out), .sync_oe_n(rxd_oe_n), .sync_data(rxd_out),
    .line_out(remote_line),
    .got_frame(got_frame), .frame(frame));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic lost(input int n);
    num_errors++;
    $display("Error at %0t: missing or extra result %0d", $time, n);
  endtask : lost

  // setup, access, hold until pready sampled high, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v, input logic [7:0] m,
    input logic err);
    int n;
    n = 0;
    if (!wr) rd_q.push_back({err, 24'hFFFFFF, m, 24'h0, v});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= ($random(seed) & 32'hFFFFFF00) | {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a hung bus abandons the scenario and goes straight to the report
    if (pready !== 1'b1) begin
      lost(0);
      disable run_scenario;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, v, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic [7:0] m);
    apb(1'b0, a, v, m, 1'b0);
  endtask : rd

  // bounded wait for every frame sent, then idle so the stop bit ends before the next write
  task automatic wait_frames();
    int n;
    n = 0;
    while (n < 800 && frames_seen != frames_sent) begin
      @(posedge pclk);
      n++;
    end
    if (frames_seen != frames_sent) lost(3);
    repeat (40) @(posedge pclk);
  endtask : wait_frames

  // read data and slave error against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rd_q.size() == 0) begin
        lost(1);
      end else begin
        e = rd_q.pop_front();
        check(prdata & e[63:32], e[31:0] & e[63:32]);
        check({31'h0, pslverr}, {31'h0, e[64]});
      end
    end
  end

  // frames seen by the remote station against the oldest note
  always @(posedge pclk) begin
    if (got_frame === 1'b1) begin
      frames_seen++;
      if (tx_q.size() == 0) lost(2);
      else check({21'h0, frame}, tx_q.pop_front());
    end
  end

  task automatic run_scenario();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, 8'h00, 8'hFF);
    rd(A_DATA, 8'h00, 8'hFF);
    rd(A_PWR, 8'h00, 8'hFF);
    apb(1'b0, 12'h004, 8'h00, 8'hFF, 1'b1);
    // mode 3, filter, receiver on, ninth bit set
    wr(A_BAUD, 8'h00);
    wr(A_CTRL, 8'hF8);
    rd(A_CTRL, 8'hF8, 8'hFF);
    // second write while busy must be dropped
    d = 8'($random(seed));
    tx_q.push_back({21'h0, 1'b1, 1'b1, d, 1'b0});
    frames_sent++;
    wr(A_DATA, d);
    wr(A_DATA, ~d);
    wait_frames();
    wr(A_PWR, 8'h40);
    rd(A_CTRL, 8'h3A, 8'hFF);
    // address byte with filter on
    wr(A_CTRL, 8'h18);
    r = 8'($random(seed));
    remote_u.send_frame(r, 1'b1, 1'b1);
    rd(A_CTRL, 8'h1D, 8'hFF);
    rd(A_DATA, r, 8'hFF);
    // data byte with filter on is dropped
    wr(A_CTRL, 8'h18);
    remote_u.send_frame(~r, 1'b0, 1'b1);
    rd(A_CTRL, 8'h18, 8'hFF);
    rd(A_DATA, r, 8'hFF);
    // two bytes, no read between
    remote_u.send_frame(d, 1'b1, 1'b1);
    remote_u.send_frame(r ^ 8'h5A, 1'b1, 1'b1);
    rd(A_CTRL, 8'h5D, 8'hFF);
    rd(A_DATA, r ^ 8'h5A, 8'hFF);
    wr(A_CTRL, 8'h18);
    remote_u.send_frame(d, 1'b1, 1'b0);
    rd(A_CTRL, 8'h80, 8'hE0);
    // receiver off
    wr(A_CTRL, 8'h08);
    remote_u.send_frame(r, 1'b1, 1'b1);
    rd(A_CTRL, 8'h08, 8'hFF);
    wr(A_PWR, 8'h00);
    rd(A_CTRL, 8'hE8, 8'hFF);
    // 8-bit mode with stop check
    wr(A_CTRL, 8'h70);
    wr(A_PWR, 8'h40);
    remote_u.send_frame(d, 1'b0, 1'b1);
    rd(A_CTRL, 8'h90, 8'h91);
    wr(A_CTRL, 8'h10);
    remote_u.send_frame(d, 1'b1, 1'b1);
    rd(A_CTRL, 8'h15, 8'hBF);
    // mode 2 at doubled fixed rate, ninth bit zero, receiver off
    wr(A_PWR, 8'h80);
    rd(A_PWR, 8'h80, 8'hFF);
    wr(A_CTRL, 8'h80);
    remote_u.bit_t = int'(`UCBR_BT_FIX_FAST);
    r = 8'($random(seed));
    tx_q.push_back({21'h0, 1'b1, 1'b0, r, 1'b0});
    frames_sent++;
    wr(A_DATA, r);
    wait_frames();
    rd(A_CTRL, 8'h82, 8'hFF);
    // sync transmit, slow then fast shift clock
    wr(A_CTRL, 8'h00);
    tx_q.push_back({24'h0, d});
    frames_sent++;
    wr(A_DATA, d);
    wait_frames();
    rd(A_CTRL, 8'h02, 8'hFF);
    wr(A_CTRL, 8'h20);
    tx_q.push_back({24'h0, r});
    frames_sent++;
    wr(A_DATA, r);
    wait_frames();
    rd(A_CTRL, 8'h22, 8'hFF);
    repeat (4) @(posedge pclk);
  endtask : run_scenario

  // one way to the verdict, whether the scenario ends or is abandoned
  initial begin
    run_scenario();
    complete_run();
  end
endmodule : test_uart_control_and_buffer_regs

// file: testbench/ucbr_remote.sv
// remote serial station: sends frames on request, captures device frames
// assumes idle-high lines, a bit time of bit_t clocks both ways; sync data arrives while sync_oe_n is low
module ucbr_remote #(
  parameter int BIT_T = 16
) (
  input wire logic pclk,
  input wire logic line_in,
  input wire logic sync_oe_n,
  input wire logic sync_data,
  output logic line_out,
  output logic got_frame,
  output logic [10:0] frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] cap;
  logic [7:0] sh;
  logic clk_q;
  int nb;
  // bit time may be changed by the bench between frames
  int bit_t = BIT_T;

  initial begin
    sh = 8'h00;
    clk_q = 1'b1;
    nb = 0;
    line_out = 1'b1;
    got_frame = 1'b0;
    frame = 11'h000;
  end

  // start low, data lsb first, ninth, stop, then one idle bit
  task automatic send_frame(input logic [7:0] d, input logic ninth, input logic stop);
    logic [10:0] bits;
    bits = {stop, ninth, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      line_out <= bits[i];
      repeat (bit_t - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line_out <= 1'b1;
    repeat (bit_t) @(posedge pclk);
  endtask : send_frame

  // mid-bit sampling; pulse got_frame once per frame
  always begin
    @(posedge pclk);
    // a low line while the device drives sync data is its shift clock, not a start bit
    if (line_in === 1'b0 && sync_oe_n !== 1'b0) begin
      repeat (bit_t / 2 - 1) @(posedge pclk);
      for (int i = 0; i < 11; i++) begin
        cap[i] = line_in;
        if (i < 10) repeat (bit_t) @(posedge pclk);
      end
      frame <= cap;
      got_frame <= 1'b1;
      @(posedge pclk);
      got_frame <= 1'b0;
    end
  end

  // sync mode: one data bit per rising shift clock, eight to a frame, lsb first
  always begin
    @(posedge pclk);
    if (sync_oe_n !== 1'b0) begin
      nb = 0;
    end else if (clk_q === 1'b0 && line_in === 1'b1) begin
      sh = {sync_data, sh[7:1]};
      nb++;
      if (nb == 8) begin
        frame <= {3'h0, sh};
        got_frame <= 1'b1;
        @(posedge pclk);
        got_frame <= 1'b0;
      end
    end
    clk_q = line_in;
  end
endmodule : ucbr_remote
